// ===== logic/midi_rx.sv
// midi_rx: 8N1 serial receiver, 16x oversampled
// assumes line is already synchronised and tick is a 16x bit-rate enable
`timescale 1ns/1ns
`include "midi_uart_params.svh"
module midi_rx
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // control
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic       line,
  // received byte
  output logic            valid,
  output logic [7:0]      data
);
  typedef struct packed {
    midi_uart_pkg::rx_state_t st;
    logic [3:0]               cnt;
    logic [2:0]               bitn;
    logic [7:0]               sh;
    logic                     vld;
  } rx_t;
  rx_t s_r;
  rx_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.vld = 1'b0;
    unique case (s_r.st)
      midi_uart_pkg::RX_IDLE:
        if (!line)
        begin
          s_nxt.st = midi_uart_pkg::RX_START;
          s_nxt.cnt = 4'h0;
        end
      midi_uart_pkg::RX_START:
        if (tick && s_r.cnt == `MID_SAMPLE)
        begin
          // glitch shorter than half a bit is not a start bit
          s_nxt.st = line ? midi_uart_pkg::RX_IDLE : midi_uart_pkg::RX_DATA;
          s_nxt.cnt = 4'h0;
          s_nxt.bitn = 3'h0;
        end
        else if (tick)
          s_nxt.cnt = s_r.cnt + 4'h1;
      midi_uart_pkg::RX_DATA:
        if (tick && s_r.cnt == `LAST_SAMPLE)
        begin
          s_nxt.sh = {line, s_r.sh[7:1]};
          s_nxt.cnt = 4'h0;
          s_nxt.bitn = s_r.bitn + 3'h1;
          if (s_r.bitn == 3'h7)
            s_nxt.st = midi_uart_pkg::RX_STOP;
        end
        else if (tick)
          s_nxt.cnt = s_r.cnt + 4'h1;
      midi_uart_pkg::RX_STOP:
        if (tick && s_r.cnt == `LAST_SAMPLE)
        begin
          // framing errors drop the byte silently
          s_nxt.vld = line;
          s_nxt.st = midi_uart_pkg::RX_IDLE;
        end
        else if (tick)
          s_nxt.cnt = s_r.cnt + 4'h1;
    endcase
    if (!enable)
      s_nxt.st = midi_uart_pkg::RX_IDLE;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_r <= '{midi_uart_pkg::RX_IDLE, 4'h0, 3'h0, 8'h00, 1'b0};
    else
      s_r <= s_nxt;
  end

  assign valid = s_r.vld;
  assign data  = s_r.sh;
endmodule // midi_rx

// ===== logic/midi_tx.sv
// midi_tx: 8N1 serial transmitter
// assumes tick is a 16x bit-rate enable; start only while ready
`timescale 1ns/1ns
`include "midi_uart_params.svh"
module midi_tx
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // byte in
  input  wire logic       tick,
  input  wire logic       start,
  input  wire logic [7:0] data,
  output logic            ready,
  // serial line
  output logic            line
);
  typedef struct packed {
    midi_uart_pkg::tx_state_t st;
    logic [3:0]               cnt;
    logic [3:0]               n;
    logic [9:0]               sh;
    logic                     ln;
  } tx_t;
  tx_t s_r;
  tx_t s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    unique case (s_r.st)
      midi_uart_pkg::TX_IDLE:
        if (start)
        begin
          s_nxt.sh = {1'b1, data, 1'b0};
          s_nxt.st = midi_uart_pkg::TX_SEND;
          s_nxt.cnt = 4'h0;
          s_nxt.n = 4'h0;
          s_nxt.ln = 1'b0;
        end
      midi_uart_pkg::TX_SEND:
        if (tick && s_r.cnt == `LAST_SAMPLE)
        begin
          s_nxt.sh = {1'b1, s_r.sh[9:1]};
          s_nxt.ln = s_r.sh[1];
          s_nxt.cnt = 4'h0;
          s_nxt.n = s_r.n + 4'h1;
          if (s_r.n == `FRAME_BITS - 4'h1)
          begin
            s_nxt.st = midi_uart_pkg::TX_IDLE;
            s_nxt.ln = 1'b1;
          end
        end
        else if (tick)
          s_nxt.cnt = s_r.cnt + 4'h1;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_r <= '{midi_uart_pkg::TX_IDLE, 4'h0, 4'h0, 10'h3FF, 1'b1};
    else
      s_r <= s_nxt;
  end

  assign ready = (s_r.st == midi_uart_pkg::TX_IDLE);
  assign line  = s_r.ln;
endmodule // midi_tx

// ===== logic/midi_uart_cmd.sv
// midi_uart_cmd: host data/status-command ports, command decoder, FIFOs, IRQ
// assumes a synchronous 8-bit register port and a 100 MHz clock
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`include "midi_uart_params.svh"
module midi_uart_cmd
#(
  parameter int DEPTH    = 16,
  parameter int TICK_DIV = `TICK_DIV
)
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // register port; cfg_sel picks config index space
  input  wire logic        cfg_sel,
  input  wire logic [15:0] addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [7:0]       rdata,
  // serial link
  input  wire logic        serial_music_input,
  output logic             serial_music_output,
  // interrupt
  output logic             irq,
  output logic [3:0]       irq_line
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [7:0] DIV_MAX = 8'(TICK_DIV - 1);
  localparam int TICK_GAP = TICK_DIV - 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || TICK_DIV < 2 || TICK_DIV > 256)
      $error("midi_uart_cmd: DEPTH must be a power of two, TICK_DIV 2..256");
  endgenerate

  typedef struct packed {
    logic [1:0]               sync;
    logic [7:0]               div;
    logic                     tick;
    midi_uart_pkg::mode_t     mode;
    logic                     ack;
    logic [7:0]               rdata;
    logic                     active;
    logic [7:0]               base_hi;
    logic [7:0]               base_lo;
    logic [3:0]               irq_sel;
    logic [DEPTH-1:0][7:0]    rxm;
    logic [DEPTH-1:0][7:0]    txm;
    logic [AW-1:0]            rxw;
    logic [AW-1:0]            rxr;
    logic [AW-1:0]            txw;
    logic [AW-1:0]            txr;
    logic [CW-1:0]            rxc;
    logic [CW-1:0]            txc;
  } st_t;
  st_t s_r;
  st_t s_nxt;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    inc = p + AW'(1);
  endfunction

  function automatic logic base_ok(input logic [15:0] b);
    base_ok = (b >= `BASE_MIN) && (b <= `BASE_MAX);
  endfunction

  logic [15:0] base;
  logic        io_hit;
  logic        data_rd;
  logic        data_wr;
  logic        stat_rd;
  logic        cmd_wr;
  logic        pass;
  logic        empty;
  logic        busy;
  logic        rx_push;
  logic        rx_pop;
  logic        tx_push;
  logic        tx_pop;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic        tx_ready;
  logic [7:0]  status;

  assign base    = {s_r.base_hi, s_r.base_lo[7:1], 1'b0};
  assign io_hit  = s_r.active && !cfg_sel && base_ok(base) && addr[15:1] == base[15:1];
  assign data_rd = io_hit && rd && addr[0] == `PORT_DATA;
  assign data_wr = io_hit && wr && addr[0] == `PORT_DATA;
  assign stat_rd = io_hit && rd && addr[0] == `PORT_STAT;
  assign cmd_wr  = io_hit && wr && addr[0] == `PORT_STAT;
  assign pass    = (s_r.mode == midi_uart_pkg::MODE_PASS);
  assign empty   = !s_r.ack && s_r.rxc == '0;
  assign busy    = (s_r.txc == FULL);
  assign status  = {empty, busy, 6'h00};

  // acknowledge outranks the FIFO, so a FIFO pop waits for it
  assign rx_pop  = data_rd && !s_r.ack && s_r.rxc != '0;
  assign rx_push = rx_valid && pass && s_r.rxc != FULL;
  assign tx_push = data_wr && pass && !busy;
  assign tx_pop  = pass && tx_ready && s_r.txc != '0;

  // UART cores: receiver sees only the second sync flop
  midi_rx u_rx
  (
    .clock  (clock),
    .rst    (rst),
    .tick   (s_r.tick),
    .enable (pass),
    .line   (s_r.sync[1]),
    .valid  (rx_valid),
    .data   (rx_byte)
  );

  midi_tx u_tx
  (
    .clock  (clock),
    .rst    (rst),
    .tick   (s_r.tick),
    .start  (tx_pop),
    .data   (s_r.txm[s_r.txr]),
    .ready  (tx_ready),
    .line   (serial_music_output)
  );

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rdata = 8'h00;
    s_nxt.sync = {s_r.sync[0], serial_music_input};
    s_nxt.tick = 1'b0;
    // bit-rate divider stops while inactive to save power
    if (!s_r.active)
      s_nxt.div = 8'h00;
    else if (s_r.div == DIV_MAX)
    begin
      s_nxt.div = 8'h00;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.div = s_r.div + 8'h01;

    // configuration space
    if (cfg_sel && wr)
    begin
      case (addr[7:0])
        `CFG_ACTIVATE: s_nxt.active = wdata[`ACTIVATE_BIT];
        `CFG_BASE_HI:  s_nxt.base_hi = wdata;
        `CFG_BASE_LO:  s_nxt.base_lo = {wdata[7:1], 1'b0};
        `CFG_IRQ_SEL:  s_nxt.irq_sel = wdata[3:0];
        default:       ;
      endcase
    end
    if (cfg_sel && rd)
    begin
      case (addr[7:0])
        `CFG_ACTIVATE: s_nxt.rdata = {7'h00, s_r.active};
        `CFG_BASE_HI:  s_nxt.rdata = s_r.base_hi;
        `CFG_BASE_LO:  s_nxt.rdata = s_r.base_lo;
        `CFG_IRQ_SEL:  s_nxt.rdata = {4'h0, s_r.irq_sel};
        default:       s_nxt.rdata = 8'h00;
      endcase
    end

    // host ports
    if (stat_rd)
      s_nxt.rdata = status;
    if (data_rd && s_r.ack)
    begin
      s_nxt.rdata = `ACK_BYTE;
      s_nxt.ack = 1'b0;
    end
    else if (rx_pop)
    begin
      s_nxt.rdata = s_r.rxm[s_r.rxr];
      s_nxt.rxr = inc(s_r.rxr);
    end
    if (rx_push)
    begin
      s_nxt.rxm[s_r.rxw] = rx_byte;
      s_nxt.rxw = inc(s_r.rxw);
    end
    s_nxt.rxc = s_r.rxc + CW'(rx_push) - CW'(rx_pop);
    if (tx_push)
    begin
      s_nxt.txm[s_r.txw] = wdata;
      s_nxt.txw = inc(s_r.txw);
    end
    if (tx_pop)
      s_nxt.txr = inc(s_r.txr);
    s_nxt.txc = s_r.txc + CW'(tx_push) - CW'(tx_pop);

    // command decoder; a flush beats a byte landing in the same cycle
    if (cmd_wr && wdata == `CMD_RESET)
    begin
      s_nxt.mode = midi_uart_pkg::MODE_RESET;
      s_nxt.rxr = s_nxt.rxw;
      s_nxt.rxc = '0;
      if (!pass)
        s_nxt.ack = 1'b1;
    end
    else if (cmd_wr && wdata == `CMD_PASS && !pass)
    begin
      s_nxt.mode = midi_uart_pkg::MODE_PASS;
      s_nxt.rxr = s_nxt.rxw;
      s_nxt.rxc = '0;
      s_nxt.txr = s_nxt.txw;
      s_nxt.txc = '0;
      s_nxt.ack = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r <= '0;
      s_r.sync <= 2'h3;
      s_r.mode <= midi_uart_pkg::MODE_RESET;
      s_r.active <= `ACTIVATE_RESET;
      s_r.base_hi <= 8'(`BASE_RESET >> 8);
      s_r.base_lo <= 8'(`BASE_RESET & 16'h00FF);
      s_r.irq_sel <= `IRQ_SEL_RESET;
    end
    else
      s_r <= s_nxt;
  end

  // level request, no transmit or line-status term
  assign irq      = s_r.active && !empty;
  assign irq_line = s_r.irq_sel;
  assign rdata    = s_r.rdata;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_irq_inactive;
    !s_r.active |-> !irq;
  endproperty
  a_irq_inactive: assert property (p_irq_inactive) else $error("irq while inactive");

  property p_irq_stays;
    data_rd && !s_r.ack && s_r.rxc > CW'(1) |=> irq;
  endproperty
  a_irq_stays: assert property (p_irq_stays) else $error("irq dropped with data left");

  property p_irq_drops;
    data_rd && s_r.ack && s_r.rxc == '0 && !rx_push |=> !irq;
  endproperty
  a_irq_drops: assert property (p_irq_drops) else $error("irq held after last read");

  property p_one_byte;
    s_r.active && !s_r.ack && s_r.rxc == '0 && rx_push && !wr |=> irq && s_r.rxc == CW'(1);
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("single byte missed irq");

  property p_reset_ack;
    cmd_wr && wdata == `CMD_RESET && !pass |=> s_r.ack && !pass && s_r.rxc == '0;
  endproperty
  a_reset_ack: assert property (p_reset_ack) else $error("reset command not acked");

  property p_reset_quiet;
    cmd_wr && wdata == `CMD_RESET && pass && !s_r.ack |=> !s_r.ack && !pass && empty;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset in pass mode acked");

  property p_pass_enter;
    cmd_wr && wdata == `CMD_PASS && !pass |=> pass && s_r.ack && s_r.txc == '0 && s_r.rxc == '0;
  endproperty
  a_pass_enter: assert property (p_pass_enter) else $error("pass command failed");

  property p_pass_again;
    cmd_wr && wdata == `CMD_PASS && pass |=> s_r.ack == $past(s_r.ack) && s_r.rxc >= $past(s_r.rxc);
  endproperty
  a_pass_again: assert property (p_pass_again) else $error("repeat pass command acted");

  property p_other_cmd;
    cmd_wr && wdata != `CMD_PASS && wdata != `CMD_RESET |=> s_r.mode == $past(s_r.mode) && s_r.ack == $past(s_r.ack);
  endproperty
  a_other_cmd: assert property (p_other_cmd) else $error("unknown command acted");

  property p_drop_reset;
    !pass && !cmd_wr |=> s_r.rxc == $past(s_r.rxc) && s_r.txc == $past(s_r.txc);
  endproperty
  a_drop_reset: assert property (p_drop_reset) else $error("data taken in reset state");

  property p_ack_first;
    data_rd && s_r.ack |=> rdata == `ACK_BYTE ##1 rdata == 8'h00;
  endproperty
  a_ack_first: assert property (p_ack_first) else $error("ack not read first");

  property p_status;
    stat_rd |=> rdata[5:0] == 6'h00 && rdata[`STAT_EMPTY_BIT] == $past(empty) && rdata[`STAT_BUSY_BIT] == $past(busy);
  endproperty
  a_status: assert property (p_status) else $error("status byte wrong");

  property p_tick_rate;
    s_r.tick |-> not (##[1:TICK_GAP] s_r.tick);
  endproperty
  a_tick_rate: assert property (p_tick_rate) else $error("bit tick too fast");

  property p_inactive_quiet;
    !s_r.active && !cfg_sel && rd |=> rdata == 8'h00;
  endproperty
  a_inactive_quiet: assert property (p_inactive_quiet) else $error("decoder answered while inactive");

  property p_busy_refuse;
    data_wr && busy |=> s_r.txc <= $past(s_r.txc);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("write taken while busy");

  property p_tx_no_irq;
    data_wr && !rx_push |=> irq == $past(irq);
  endproperty
  a_tx_no_irq: assert property (p_tx_no_irq) else $error("transmit write moved irq");
endmodule // midi_uart_cmd

// ===== logic/midi_uart_params.svh
// midi_uart_params.svh: port offsets, config indices, reset values, timing
// assumes a 100 MHz clock; included by bare name
`ifndef MIDI_UART_PARAMS_SVH
`define MIDI_UART_PARAMS_SVH
`define CFG_ACTIVATE   8'h30
`define CFG_BASE_HI    8'h60
`define CFG_BASE_LO    8'h61
`define CFG_IRQ_SEL    8'h70
`define PORT_DATA      1'b0
`define PORT_STAT      1'b1
`define CMD_RESET      8'hFF
`define CMD_PASS       8'h3F
`define ACK_BYTE       8'hFE
`define STATUS_RESET   8'h80
`define STAT_EMPTY_BIT 7
`define STAT_BUSY_BIT  6
`define ACTIVATE_BIT   0
`define ACTIVATE_RESET 1'b0
`define IRQ_SEL_RESET  4'h5
`define BASE_RESET     16'h0330
`define BASE_MIN       16'h0100
`define BASE_MAX       16'h0FFE
`define CLOCK_HZ       100000000
`define BAUD_RATE      31250
`define OVERSAMPLE     16
`define TICK_DIV       (`CLOCK_HZ / (`BAUD_RATE * `OVERSAMPLE))
`define MID_SAMPLE     4'h7
`define LAST_SAMPLE    4'hF
`define FRAME_BITS     4'hA
`endif

// ===== logic/midi_uart_pkg.sv
// midi_uart_pkg: state and mode types of the serial command interface
// assumes the params header for all numeric constants
package midi_uart_pkg;
  typedef enum logic {MODE_RESET = 1'b0, MODE_PASS = 1'b1} mode_t;
  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11} rx_state_t;
  typedef enum logic {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;
endpackage

// ===== tb/midi_instrument.sv
// midi_instrument: behavioural instrument on the far end of the serial link
// assumes the link idles high and one bit lasts BIT_CYCLES clocks
`timescale 1ns/1ns
module midi_instrument
#(
  parameter int BIT_CYCLES = 64
)
(
  // clock
  input  wire logic clock,
  // serial link
  input  wire logic from_device,
  output logic      to_device
);
  logic [7:0] heard[$];
  logic       frame_error;
  logic [7:0] shift;

  initial to_device = 1'b1;

  // one idle bit after every frame keeps frames apart
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      to_device <= frame[i];
      repeat (BIT_CYCLES) @(posedge clock);
    end
    to_device <= 1'b1;
    repeat (BIT_CYCLES) @(posedge clock);
  endtask

  // samples every data bit and the stop bit in its middle
  initial
  begin
    frame_error = 1'b0;
    forever
    begin
      @(negedge from_device);
      repeat (BIT_CYCLES / 2) @(posedge clock);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES) @(posedge clock);
        shift[i] = from_device;
      end
      repeat (BIT_CYCLES) @(posedge clock);
      if (from_device !== 1'b1)
        frame_error = 1'b1;
      heard.push_back(shift);
    end
  end
endmodule // midi_instrument

// ===== tb/midi_uart_cmd_test.sv
// midi_uart_cmd_test: self-checking bench for the serial command interface
// assumes the instrument model on the serial pins and the params header
`timescale 1ns/1ns
`include "midi_uart_params.svh"
module midi_uart_cmd_test;
  localparam int TDIV = 4;
  localparam int BITC = 16 * TDIV;
  logic        clock;
  logic        rst;
  logic        cfg_sel;
  logic [15:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        to_dev;
  logic        from_dev;
  logic        irq;
  logic [3:0]  irq_line;
  int          mismatches;
  int          total_checks;
  logic [7:0]  q;
  logic [7:0]  b;
  logic [7:0]  sent[$];

  midi_uart_cmd #(.DEPTH(16), .TICK_DIV(TDIV)) u_midi_uart_cmd (.clock(clock), .rst(rst), .cfg_sel(cfg_sel),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serial_music_input(to_dev),
    .serial_music_output(from_dev), .irq(irq), .irq_line(irq_line));
  midi_instrument #(.BIT_CYCLES(BITC)) u_midi_instrument (.clock(clock), .from_device(from_dev),
    .to_device(to_dev));

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  function automatic logic [7:0] stat_exp(input logic waiting, input logic full);
    return {~waiting, full, 6'h00};
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_up(input string what);
    mismatches++;
    $display("[ERR] %s expected done seen timeout", what);
    tally_and_finish();
  endtask

  // one strobe cycle; read data taken at the edge after the strobe
  task automatic acc(input logic c, input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clock);
    cfg_sel <= c;
    addr    <= a;
    wdata   <= d;
    wr      <= w;
    rd      <= ~w;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
    q = rdata;
  endtask

  task automatic rchk(input string what, input logic c, input logic [15:0] a, input logic [7:0] exp);
    acc(c, a, 1'b0, 8'h00);
    check(what, q, exp);
  endtask

  task automatic chk_irq(input logic exp);
    #1;
    check("irq", {7'h00, irq}, {7'h00, exp});
  endtask

  // host polls status and writes only once busy reads zero
  task automatic wait_ready();
    acc(1'b0, 16'h0331, 1'b0, 8'h00);
    for (int n = 0; n < 1000 && q[`STAT_BUSY_BIT] !== 1'b0; n++)
      acc(1'b0, 16'h0331, 1'b0, 8'h00);
    if (q[`STAT_BUSY_BIT] !== 1'b0)
      give_up("busy wait");
  endtask

  task automatic wait_irq();
    for (int n = 0; n < 2000 && irq !== 1'b1; n++)
      @(posedge clock);
    if (irq !== 1'b1)
      give_up("irq wait");
  endtask

  // waits for the instrument to hear every queued byte, then 12 bit times more
  task automatic tx_cmp();
    for (int n = 0; n < 20000 && u_midi_instrument.heard.size() < sent.size(); n++)
      @(posedge clock);
    if (u_midi_instrument.heard.size() < sent.size())
      give_up("tx wait");
    repeat (BITC * 12) @(posedge clock);
    check("tx count", 8'(u_midi_instrument.heard.size()), 8'(sent.size()));
    check("stop bit", {7'h00, u_midi_instrument.frame_error}, 8'h00);
    foreach (sent[i])
      check("tx byte", u_midi_instrument.heard[i], sent[i]);
    sent.delete();
    u_midi_instrument.heard.delete();
  endtask

  initial
  begin
    rst = 1'b1;
    cfg_sel = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    mismatches = 0;
    total_checks = 0;
    q = 8'($urandom(54));
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    check("irq line", {4'h0, irq_line}, 8'h05);
    check("serial idle", {7'h00, from_dev}, 8'h01);
    acc(1'b0, 16'h0331, 1'b1, `CMD_PASS);
    rchk("inactive status", 1'b0, 16'h0331, 8'h00);
    acc(1'b1, 16'h0030, 1'b1, 8'h01);
    rchk("status", 1'b0, 16'h0331, stat_exp(1'b0, 1'b0));
    rchk("unmapped port", 1'b0, 16'h0332, 8'h00);
    rchk("unmapped index", 1'b1, 16'h0042, 8'h00);
    u_midi_instrument.send_byte(8'hA5);
    acc(1'b0, 16'h0330, 1'b1, 8'h5A);
    repeat (BITC * 11) @(posedge clock);
    chk_irq(1'b0);
    check("dropped tx", 8'(u_midi_instrument.heard.size()), 8'h00);
    acc(1'b0, 16'h0331, 1'b1, 8'h12);
    rchk("unknown cmd", 1'b0, 16'h0331, stat_exp(1'b0, 1'b0));
    $display("test reset state done");
    acc(1'b0, 16'h0331, 1'b1, `CMD_RESET);
    chk_irq(1'b1);
    rchk("reset ack", 1'b0, 16'h0330, 8'hFE);
    chk_irq(1'b0);
    acc(1'b0, 16'h0331, 1'b1, `CMD_PASS);
    chk_irq(1'b1);
    rchk("ack waiting", 1'b0, 16'h0331, stat_exp(1'b1, 1'b0));
    rchk("pass ack", 1'b0, 16'h0330, 8'hFE);
    rchk("ack taken", 1'b0, 16'h0331, stat_exp(1'b0, 1'b0));
    $display("test commands done");
    for (int i = 0; i < 4; i++)
    begin
      b = (i == 0) ? 8'h80 : 8'($urandom);
      fork
        u_midi_instrument.send_byte(b);
        begin
          wait_ready();
          acc(1'b0, 16'h0330, 1'b1, ~b);
          sent.push_back(~b);
          chk_irq(1'b0);
        end
      join
      wait_irq();
      rchk("rx byte", 1'b0, 16'h0330, b);
      chk_irq(1'b0);
    end
    tx_cmp();
    $display("test pass traffic done");
    u_midi_instrument.send_byte(8'h11);
    u_midi_instrument.send_byte(8'h22);
    wait_irq();
    acc(1'b0, 16'h0331, 1'b1, `CMD_PASS);
    rchk("no second ack", 1'b0, 16'h0330, 8'h11);
    chk_irq(1'b1);
    rchk("second byte", 1'b0, 16'h0330, 8'h22);
    chk_irq(1'b0);
    u_midi_instrument.send_byte(8'h44);
    wait_irq();
    acc(1'b0, 16'h0331, 1'b1, `CMD_RESET);
    chk_irq(1'b0);
    rchk("no pass ack", 1'b0, 16'h0331, stat_exp(1'b0, 1'b0));
    rchk("flushed", 1'b0, 16'h0330, 8'h00);
    $display("test pass commands done");
    acc(1'b0, 16'h0331, 1'b1, `CMD_PASS);
    acc(1'b1, 16'h0030, 1'b1, 8'h00);
    chk_irq(1'b0);
    acc(1'b1, 16'h0030, 1'b1, 8'h01);
    chk_irq(1'b1);
    rchk("ack after activate", 1'b0, 16'h0330, 8'hFE);
    for (int i = 0; i < 18; i++)
    begin
      b = 8'($urandom);
      acc(1'b0, 16'h0330, 1'b1, b);
      if (i < 17)
        sent.push_back(b);
      if (i == 16)
        rchk("tx full", 1'b0, 16'h0331, stat_exp(1'b0, 1'b1));
    end
    tx_cmp();
    $display("test burst done");
    acc(1'b1, 16'h0060, 1'b1, 8'h03);
    acc(1'b1, 16'h0061, 1'b1, 8'h01);
    rchk("new base", 1'b0, 16'h0301, stat_exp(1'b0, 1'b0));
    rchk("old base", 1'b0, 16'h0331, 8'h00);
    rchk("even base", 1'b1, 16'h0061, 8'h00);
    acc(1'b1, 16'h0060, 1'b1, 8'h0F);
    acc(1'b1, 16'h0061, 1'b1, 8'hFE);
    rchk("top base", 1'b0, 16'h0FFF, stat_exp(1'b0, 1'b0));
    acc(1'b1, 16'h0060, 1'b1, 8'h00);
    acc(1'b1, 16'h0061, 1'b1, 8'h50);
    rchk("low base", 1'b0, 16'h0051, 8'h00);
    $display("test base done");
    tally_and_finish();
  end
endmodule // midi_uart_cmd_test
